//--- pkg/lss_params.svh
// Constants of the logic supply supervisor
`ifndef LSS_PARAMS_SVH
`define LSS_PARAMS_SVH
`define LSS_CLK_MHZ 200
`define LSS_POR_DELAY_US 500
`define LSS_POR_CYCLES ((`LSS_POR_DELAY_US * `LSS_CLK_MHZ))
`define LSS_FIL_MIN_US 60
`define LSS_FIL_MAX_US 135
`define LSS_FIL_NOM_US 100
`define LSS_FIL_CYCLES ((`LSS_FIL_NOM_US * `LSS_CLK_MHZ))
`define LSS_CNT_W 17
`define LSS_STAT_OV_BIT 0
`define LSS_STAT_UV_BIT 1
`define LSS_STAT_OK_BIT 2
`define LSS_CFG_LATCH_BIT 3
`define LSS_STAT_RESET 8'h07
`define LSS_TEST_SEL_BIT 6
`define LSS_TEST_NORM_BIT 7
`endif

//--- pkg/lss_pkg.sv
// Types of the logic supply supervisor
package lss_pkg;
  typedef enum logic [1:0] {
    LSS_OFF = 2'b00,
    LSS_POR = 2'b01,
    LSS_RUN = 2'b10
  } lss_state_t;
  typedef enum logic [1:0] {
    LSS_TM_NORMAL = 2'b00,
    LSS_TM_HIGH = 2'b01,
    LSS_TM_LOW = 2'b10
  } lss_test_t;
endpackage

//--- src/lss_filter.sv
// Glitch filter: output follows input after a stable run
`timescale 1ns/1ps
`include "lss_params.svh"
module lss_filter
  import lss_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic raw_i,
  output logic filt_o
);
  typedef struct packed {
    logic [`LSS_CNT_W-1:0] cnt;
    logic filt;
  } lss_filt_t;
  lss_filt_t s_reg;
  lss_filt_t s_next;
  localparam logic [`LSS_CNT_W-1:0] FIL_LAST =
    `LSS_CNT_W'(`LSS_FIL_CYCLES - 1);
  // Count while input disagrees with output; a glitch restarts the count
  always_comb begin
    s_next = s_reg;
    if (clr_i) begin
      s_next.cnt = '0;
      s_next.filt = 1'b0;
    end else if (raw_i == s_reg.filt) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == FIL_LAST) begin
      s_next.cnt = '0;
      s_next.filt = raw_i;
    end else begin
      s_next.cnt = s_reg.cnt + `LSS_CNT_W'(1);
    end
  end
  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign filt_o = s_reg.filt;
endmodule

//--- src/lss_supervisor.sv
// Logic supply supervisor top
// Function
// - Grounded io supply pin selects flag mode
// - Above functional reset: stages off, registers cleared
// - Start only after power-on-reset delay
// - Supply out of window: stages off, line low
// - Out-of-range detection passes a glitch filter
// - Monitor state kept in status register
// - External low on line turns stages off
// - Supply fault keeps stages off despite line
// - Fault refuses switch-on, always honours switch-off
// - Below POR level: stages off immediately
// - Monitor control and OV/UV detail: SPI only
// - Flag mode: normal thresholds, no test, no latch
// - Undervoltage: off after filter, line low
// - UV recovery: release line after filter
// - Fault freezes diagnostics, config writes allowed
// - POR rise: delayed reset, registers to default
// - Overvoltage: off after filter, line low
// - Latch enabled: overvoltage shutdown stays latched
// - Latch clear: recover after filter expires
// - Test high: OV threshold lowered, bits 2,0 low
// - Test low: UV threshold raised, bits 2,1 low
// - POR delay within maximum
// - Filter time within its limits
`timescale 1ns/1ps
`include "lss_params.svh"
module lss_supervisor
  import lss_pkg::*;
#(
  parameter int POR_CYCLES = `LSS_POR_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic vdd_func_i,
  input wire logic vdd_por_i,
  input wire logic vdd_above_thh_i,
  input wire logic vdd_below_thl_i,
  input wire logic vdd_above_test_h_i,
  input wire logic vdd_below_test_l_i,
  input wire logic io_supply_mode_pin_i,
  input wire logic fault_shutdown_line_i,
  input wire logic spi_wr_i,
  input wire logic [7:0] spi_wdata_i,
  input wire logic out_on_req_i,
  input wire logic out_off_req_i,
  input wire logic diag_event_i,
  output logic [7:0] supply_status_control_reg_o,
  output logic spi_active_o,
  output logic fault_shutdown_line_o,
  output logic fault_shutdown_line_oe_o,
  output logic stages_enable_o,
  output logic diag_log_enable_o,
  output logic regs_clear_o,
  output logic [1:0] test_mode_o
);
  // State of the supervisor outside the two glitch filters
  typedef struct packed {
    lss_state_t st;
    logic [18:0] por_cnt;
    logic latch_en;
    logic ov_latched;
    lss_test_t tm;
    logic out_on;
    logic diag_seen;
  } lss_sup_t;
  lss_sup_t s_reg;
  lss_sup_t s_next;
  logic ov_raw; // Overvoltage against the active threshold
  logic uv_raw; // Undervoltage against the active threshold
  logic ov_filt; // Filtered overvoltage
  logic uv_filt; // Filtered undervoltage
  logic flag_mode; // Flag mode selected by the io supply pin
  logic supply_fault; // Filtered or latched supply fault
  logic in_run; // Normal operation
  logic mon_clr; // Filters held clear outside operation
  localparam logic [18:0] POR_LAST = 19'(POR_CYCLES - 1);

  // Grounded io supply pin forces flag mode and silences the SPI
  assign flag_mode = !io_supply_mode_pin_i;
  assign spi_active_o = !flag_mode;

  // Threshold selection; test thresholds only reachable in SPI mode
  always_comb begin
    ov_raw = vdd_above_thh_i;
    uv_raw = vdd_below_thl_i;
    if (!flag_mode && s_reg.tm == LSS_TM_HIGH) begin
      ov_raw = vdd_above_test_h_i;
    end else if (!flag_mode && s_reg.tm == LSS_TM_LOW) begin
      uv_raw = vdd_below_test_l_i;
    end
  end

  assign in_run = (s_reg.st == LSS_RUN);
  assign mon_clr = !in_run;

  // Filters suppress short supply excursions in both directions
  lss_filter u_ov_filter (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clr_i(mon_clr),
    .raw_i(ov_raw),
    .filt_o(ov_filt)
  );
  lss_filter u_uv_filter (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .clr_i(mon_clr),
    .raw_i(uv_raw),
    .filt_o(uv_filt)
  );

  // Latched overvoltage keeps the fault even after the supply recovers
  assign supply_fault = ov_filt || uv_filt || s_reg.ov_latched;

  // Next state: power sequencing, configuration and output request
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      LSS_OFF: begin
        // Functional but below POR: everything held cleared
        s_next = '0;
        s_next.st = LSS_OFF;
        if (vdd_func_i && vdd_por_i) begin
          s_next.st = LSS_POR;
        end
      end
      LSS_POR: begin
        // Delay counted before operation starts
        if (s_reg.por_cnt == POR_LAST) begin
          s_next.st = LSS_RUN;
          s_next.por_cnt = '0;
        end else begin
          s_next.por_cnt = s_reg.por_cnt + 19'(1);
        end
      end
      LSS_RUN: begin
        // Overvoltage capture when the latch is armed, not in flag mode
        if (ov_filt && s_reg.latch_en && !flag_mode) begin
          s_next.ov_latched = 1'b1;
        end
        // Configuration writes accepted even during a fault
        if (spi_wr_i && !flag_mode) begin
          s_next.latch_en = spi_wdata_i[`LSS_CFG_LATCH_BIT];
          if (spi_wdata_i[`LSS_CFG_LATCH_BIT] != s_reg.latch_en) begin
            s_next.ov_latched = 1'b0;
          end
          if (spi_wdata_i[`LSS_TEST_NORM_BIT]) begin
            s_next.tm = LSS_TM_NORMAL;
          end else if (spi_wdata_i[`LSS_TEST_SEL_BIT]) begin
            s_next.tm = LSS_TM_LOW;
          end else begin
            s_next.tm = LSS_TM_HIGH;
          end
        end
        // Flag mode: no test, no latch
        if (flag_mode) begin
          s_next.tm = LSS_TM_NORMAL;
          s_next.latch_en = 1'b0;
          s_next.ov_latched = 1'b0;
        end
        // Switch-off always honoured, switch-on refused during a fault
        if (out_off_req_i) begin
          s_next.out_on = 1'b0;
        end else if (out_on_req_i && !supply_fault) begin
          s_next.out_on = 1'b1;
        end
        // Shutdown line resets the output drive; host must rewrite
        if (supply_fault || !fault_shutdown_line_i) begin
          s_next.out_on = 1'b0;
        end
        // Diagnostics frozen during a supply fault
        if (diag_event_i && !supply_fault) begin
          s_next.diag_seen = 1'b1;
        end
      end
      default: begin
        s_next = '0;
      end
    endcase
    // Falling below POR: immediate, unfiltered shutdown and reset
    if (!vdd_por_i || !vdd_func_i) begin
      s_next = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Status: bit0 no OV, bit1 no UV, bit2 supply good, bit3 latch enable
  always_comb begin
    supply_status_control_reg_o = `LSS_STAT_RESET;
    if (in_run) begin
      supply_status_control_reg_o[`LSS_STAT_OV_BIT] = !ov_filt;
      supply_status_control_reg_o[`LSS_STAT_UV_BIT] = !uv_filt;
      supply_status_control_reg_o[`LSS_STAT_OK_BIT] = !supply_fault;
      supply_status_control_reg_o[`LSS_CFG_LATCH_BIT] = s_reg.latch_en;
      // Separate OV/UV detail visible only in SPI mode
      if (flag_mode) begin
        supply_status_control_reg_o[`LSS_STAT_OV_BIT] = !supply_fault;
        supply_status_control_reg_o[`LSS_STAT_UV_BIT] = !supply_fault;
      end
    end
  end

  // Line driven low whenever not running or a supply fault stands
  assign fault_shutdown_line_oe_o = !in_run || supply_fault;
  assign fault_shutdown_line_o = 1'b0;
  // Supply fault wins over a shorted-high line; external low also stops
  assign stages_enable_o = in_run && !supply_fault
    && fault_shutdown_line_i && s_reg.out_on;
  assign diag_log_enable_o = in_run && !supply_fault;
  assign regs_clear_o = !in_run;
  assign test_mode_o = s_reg.tm;
endmodule

//--- bench/lss_host.sv
// Host side of the shared shutdown line
`timescale 1ns/1ps
module lss_host (
  input wire logic pull_low_i,
  input wire logic short_high_i,
  input wire logic dut_oe_i,
  output logic line_o
);
  // Wired-low line; a short to a high rail beats any pull
  assign line_o = short_high_i | !(pull_low_i | dut_oe_i);
endmodule

//--- bench/lss_supervisor_monitor.sv
// Assertion checker on the supervisor ports
`timescale 1ns/1ps
`include "lss_params.svh"
module lss_supervisor_monitor
  import lss_pkg::*;
#(parameter int POR_CYCLES = 50)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic vdd_func_i,
  input wire logic vdd_por_i,
  input wire logic vdd_above_thh_i,
  input wire logic vdd_below_thl_i,
  input wire logic vdd_above_test_h_i,
  input wire logic io_supply_mode_pin_i,
  input wire logic fault_shutdown_line_i,
  input wire logic spi_wr_i,
  input wire logic [7:0] spi_wdata_i,
  input wire logic [7:0] supply_status_control_reg_o,
  input wire logic spi_active_o,
  input wire logic fault_shutdown_line_oe_o,
  input wire logic stages_enable_o,
  input wire logic regs_clear_o,
  input wire logic [1:0] test_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // Run lengths; the UV test threshold is left unwatched
  logic [16:0] por_cnt, bad_cnt, good_cnt;
  logic bad, ov_lat;
  assign bad = vdd_above_thh_i | vdd_below_thl_i |
    (test_mode_o == LSS_TM_HIGH & vdd_above_test_h_i);
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      por_cnt <= '0;
      bad_cnt <= '0;
      good_cnt <= '0;
      ov_lat <= 1'b0;
    end else begin
      // Counts only while the supply is up and the block is still held
      por_cnt <= (vdd_func_i & vdd_por_i & regs_clear_o) ?
        por_cnt + 17'h1 : '0;
      bad_cnt <= bad ? bad_cnt + 17'h1 : '0;
      good_cnt <= bad ? '0 : good_cnt + 17'h1;
      // Overvoltage shutdown seen, held until the line is let go
      ov_lat <= fault_shutdown_line_oe_o &
        (ov_lat | !supply_status_control_reg_o[0]);
    end
  end
  sequence spi_run;
    io_supply_mode_pin_i && !regs_clear_o;
  endsequence
  sequence wr_high;
    spi_wr_i && spi_wdata_i[7:6] == 2'b00;
  endsequence
  flag_spi_off_a:
    assert property (!io_supply_mode_pin_i |-> !spi_active_o)
    else $error("spi active in flag mode");
  clear_off_a:
    assert property (regs_clear_o |-> !stages_enable_o &&
      supply_status_control_reg_o == `LSS_STAT_RESET) else $error("not clear");
  por_delay_a:
    assert property ($fell(regs_clear_o) |-> por_cnt >= POR_CYCLES - 1 &&
      por_cnt <= POR_CYCLES + 3) else $error("start delay wrong");
  line_off_a:
    assert property (!fault_shutdown_line_i |-> !stages_enable_o)
    else $error("stages on with line low");
  pull_off_a:
    assert property (fault_shutdown_line_oe_o |-> !stages_enable_o)
    else $error("stages on while pulling");
  filter_off_a:
    // A power-on reset pulls the line at once, so it is left out here
    assert property ($rose(fault_shutdown_line_oe_o) && $past(vdd_por_i) &&
      $past(vdd_func_i) &&
      $past(fault_shutdown_line_i) && !$past(regs_clear_o) |->
      bad_cnt >= `LSS_FIL_CYCLES - 2) else $error("fault not filtered");
  filter_on_a:
    assert property ($fell(fault_shutdown_line_oe_o) && !$past(regs_clear_o)
      |-> good_cnt >= `LSS_FIL_CYCLES - 2) else $error("early release");
  latch_hold_a:
    assert property (ov_lat && supply_status_control_reg_o[3] && vdd_por_i &&
      io_supply_mode_pin_i && !spi_wr_i |=> fault_shutdown_line_oe_o)
    else $error("latched line let go");
  test_high_a:
    assert property (spi_run ##0 wr_high |=> test_mode_o == LSS_TM_HIGH)
    else $error("test high not taken");
endmodule

//--- bench/tb.sv
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`include "lss_params.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
  import lss_pkg::*;
  localparam int POR = 50;
  logic sys_clk_i = 0, nrst_i = 0, vdd_func_i = 0, vdd_por_i = 0;
  logic vdd_above_thh_i = 0, vdd_below_thl_i = 0, vdd_above_test_h_i = 0;
  logic vdd_below_test_l_i = 0, io_supply_mode_pin_i = 1, spi_wr_i = 0;
  logic out_on_req_i = 0, out_off_req_i = 0, diag_event_i = 0;
  logic pull_low = 0, short_high = 0, fault_shutdown_line_i;
  logic [7:0] spi_wdata_i = 8'h00, supply_status_control_reg_o;
  logic spi_active_o, fault_shutdown_line_o, fault_shutdown_line_oe_o;
  logic stages_enable_o, diag_log_enable_o, regs_clear_o;
  logic [1:0] test_mode_o;
  int fail_count = 0, tests_run = 0, seed = 32'h16e1, n, r;
  int m_latch = 0, m_tm = 0, m_uv = 0, m_ov = 0; // Reference model state
  always #2.5 sys_clk_i = ~sys_clk_i;
  lss_supervisor #(.POR_CYCLES(POR)) dut (.sys_clk_i, .nrst_i, .vdd_func_i,
    .vdd_por_i, .vdd_above_thh_i, .vdd_below_thl_i, .vdd_above_test_h_i,
    .vdd_below_test_l_i, .io_supply_mode_pin_i, .fault_shutdown_line_i,
    .spi_wr_i, .spi_wdata_i, .out_on_req_i, .out_off_req_i, .diag_event_i,
    .supply_status_control_reg_o, .spi_active_o, .fault_shutdown_line_o,
    .fault_shutdown_line_oe_o, .stages_enable_o, .diag_log_enable_o,
    .regs_clear_o, .test_mode_o);
  lss_host host (.pull_low_i(pull_low), .short_high_i(short_high),
    .dut_oe_i(fault_shutdown_line_oe_o), .line_o(fault_shutdown_line_i));
  // Expected status: bit2 ok, bit1 no UV, bit0 no OV
  function automatic logic [7:0] m_stat();
    return {4'h0, m_latch[0], !(m_uv | m_ov), !m_uv, !m_ov};
  endfunction
  task automatic tick(int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write with random filler bits; the model follows only in SPI mode
  task automatic wr(logic [1:0] hi, logic lat);
    r = $random(seed);
    spi_wdata_i = {hi, r[5:4], lat, r[2:0]};
    spi_wr_i = 1;
    tick(1);
    spi_wr_i = 0;
    tick(1);
    if (io_supply_mode_pin_i) begin
      m_latch = lat;
      m_tm = hi[1] ? 0 : (hi[0] ? 2 : 1);
    end
  endtask
  task automatic pulse_on();
    out_on_req_i = 1;
    tick(1);
    out_on_req_i = 0;
  endtask
  // Bounded waits; running out counts as a mismatch
  task automatic wait_oe(logic v);
    n = 0;
    while (fault_shutdown_line_oe_o !== v && n < 21000) begin
      tick(1);
      n++;
    end
    if (n >= 21000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic wait_run();
    n = 0;
    while (regs_clear_o !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      end_of_test();
    end
  endtask
  initial begin
    tick(10);
    nrst_i = 1;
    vdd_func_i = 1;
    vdd_por_i = 1;
    wait_run();
    `CHK("status", m_stat(), supply_status_control_reg_o)
    io_supply_mode_pin_i = 0;
    tick(2);
    `CHK("spi", 1'b0, spi_active_o)
    wr(2'b00, 1'b0);
    `CHK("flag test", LSS_TM_NORMAL, test_mode_o)
    io_supply_mode_pin_i = 1;
    wr(2'b01, 1'b0);
    `CHK("low test", LSS_TM_LOW, test_mode_o)
    wr(2'b10, 1'b0);
    `CHK("normal", LSS_TM_NORMAL, test_mode_o)
    pulse_on();
    `CHK("on", 1'b1, stages_enable_o)
    vdd_below_thl_i = 1;
    tick(1 + (($random(seed)) & 1023));
    vdd_below_thl_i = 0;
    tick(2);
    `CHK("glitch", 1'b1, stages_enable_o)
    pull_low = 1;
    tick(1);
    `CHK("pulled", 1'b0, stages_enable_o)
    pull_low = 0;
    pulse_on(); // Host reissues the drive
    vdd_below_thl_i = 1;
    m_uv = 1;
    wait_oe(1);
    `CHK("uv status", m_stat(), supply_status_control_reg_o)
    pulse_on();
    short_high = 1;
    diag_event_i = 1;
    tick(2);
    `CHK("refused", 1'b0, stages_enable_o)
    `CHK("diag", 1'b0, diag_log_enable_o)
    short_high = 0;
    diag_event_i = 0;
    wr(2'b10, 1'b1);
    `CHK("cfg", m_stat(), supply_status_control_reg_o)
    wr(2'b10, 1'b0); // Latch cleared before testing
    vdd_below_thl_i = 0;
    m_uv = 0;
    wait_oe(0);
    `CHK("uv back", m_stat(), supply_status_control_reg_o)
    pulse_on();
    `CHK("resumed", 1'b1, stages_enable_o)
    wr(2'b00, 1'b0);
    vdd_above_test_h_i = 1;
    m_ov = 1;
    wait_oe(1);
    `CHK("test ov", m_stat(), supply_status_control_reg_o)
    vdd_above_thh_i = 1;
    vdd_above_test_h_i = 0;
    wr(2'b10, 1'b1);
    `CHK("ov latch", m_stat(), supply_status_control_reg_o)
    vdd_above_thh_i = 0;
    m_ov = 0;
    tick(20100);
    `CHK("held", 1'b1, fault_shutdown_line_oe_o)
    wr(2'b10, 1'b0);
    wait_oe(0);
    `CHK("freed", m_stat(), supply_status_control_reg_o)
    wr(2'b10, 1'b1);
    pulse_on();
    vdd_por_i = 0;
    tick(1);
    `CHK("por off", 1'b0, stages_enable_o)
    vdd_por_i = 1;
    m_latch = 0;
    tick(2);
    wait_run();
    `CHK("defaults", m_stat(), supply_status_control_reg_o)
    end_of_test();
  end
endmodule
bind lss_supervisor lss_supervisor_monitor #(.POR_CYCLES(POR_CYCLES)) mon (
  .sys_clk_i, .nrst_i, .vdd_func_i, .vdd_por_i, .vdd_above_thh_i,
  .vdd_below_thl_i, .vdd_above_test_h_i, .io_supply_mode_pin_i,
  .fault_shutdown_line_i, .spi_wr_i, .spi_wdata_i,
  .supply_status_control_reg_o, .spi_active_o, .fault_shutdown_line_oe_o,
  .stages_enable_o, .regs_clear_o, .test_mode_o);
